//--- verilog/core_cfg.svh
`ifndef CORE_CFG_SVH
`define CORE_CFG_SVH
// How it works
// [RULE1] Each instruction is one 14-bit word: opcode and operands, no extensions.
// [RULE2] One instruction cycle each, calls direct or through W take two.
// [RULE3] Return, return with literal and return from interrupt take two.
// [RULE4] Jumps, branches and taken skips take two instruction cycles; a relative branch word decodes as load literal here and takes one.
// [RULE5] One extra cycle when indirect access points into program memory.
// [RULE6] One instruction cycle is four oscillator cycles.
// [RULE7] File instructions read, modify, then write where the opcode or d says.
// [RULE8] The file read happens even when the instruction only writes.
// [RULE9] The file operand is a 7-bit bank offset, 0x00 to 0x7F.
// [RULE10] The bit operand selects one bit of the 8-bit file register.
// [RULE11] d = 0 stores the result in W, d = 1 in the file register.
// [RULE12] Don't-care opcode bits are ignored whatever their value.
// [RULE13] The pointer operand selects pointer or indirect register 0 or 1.
// [RULE14] The step mode picks pre/post increment or decrement of the pointer.
// [RULE15] Add with carry is 11 1101 d f, sets C, DC, Z, one cycle.
// [RULE16] Rotate right through carry is 00 1100 d f, changes only C.
// [RULE17] Fetch stalls during extra cycles; nothing follows early.
// [RULE18] Words are classed byte, bit or literal/control before field extraction.

// ----------------------------------------------------------------
// Widths and timing
// ----------------------------------------------------------------
`define INSTR_W         14
`define FILE_F_W        7
`define DATA_W          8
`define PTR_W           16
`define PTR_PROG_BIT    15
`define PC_W_DEFAULT    15
`define STACK_DEPTH     16
`define OSC_PER_ICYC    4
`define NOP_WORD        14'h0000
`define INDIRECT_LAST   7'h01

// ----------------------------------------------------------------
// Opcode patterns
// ----------------------------------------------------------------
`define GRP_BYTE        2'h0
`define GRP_BIT         2'h1
`define GRP_K11         2'h2
`define OPC_STORE_W     6'h00
`define OPC_CLEAR       6'h01
`define OPC_SUB         6'h02
`define OPC_DEC         6'h03
`define OPC_OR          6'h04
`define OPC_AND         6'h05
`define OPC_ADD         6'h07
`define OPC_MOVE_F      6'h08
`define OPC_COMPL       6'h09
`define OPC_INC         6'h0A
`define OPC_DEC_SKIP    6'h0B
`define OPC_ROT_RIGHT   6'h0C
`define OPC_ROT_LEFT    6'h0D
`define OPC_INC_SKIP    6'h0F
`define OPC_ADD_CARRY   6'h3D
`define OPC_OR_LIT      6'h38
`define OPC_AND_LIT     6'h39
`define OPC_ADD_LIT     6'h3E
`define OPC_LOAD_LIT    4'hC
`define OPC_RET_LIT     4'hD
`define OPC_REL_BRANCH  5'h19
`define OPC_CALL        1'h0
`define OPC_RETURN      7'h08
`define OPC_RET_INT     7'h09
`define OPC_CALL_W      7'h0A
`define OPC_BRANCH_W    7'h0B
`define OPC_PTR_LOAD    4'h2
`define OPC_PTR_STORE   4'h3
`endif

//--- verilog/core_pkg.sv
package core_pkg;

  // One-hot oscillator phase within an instruction cycle
  typedef enum logic [3:0] {
    PH_Q1 = 4'h1,
    PH_Q2 = 4'h2,
    PH_Q3 = 4'h4,
    PH_Q4 = 4'h8
  } phase_t;

  typedef enum logic [1:0] {
    CLS_BYTE    = 2'h0,
    CLS_BIT     = 2'h1,
    CLS_LITCTRL = 2'h2
  } class_t;

  typedef enum logic [5:0] {
    OP_NOP, OP_ADD, OP_ADD_WITH_CARRY, OP_SUB, OP_DEC, OP_INC, OP_OR,
    OP_AND, OP_MOVE_F, OP_COMPL, OP_DEC_SKIP_ZERO, OP_INC_SKIP_ZERO,
    OP_ROT_RIGHT, OP_ROT_LEFT, OP_STORE_W, OP_CLEAR_F, OP_CLEAR_W,
    OP_BIT_CLR, OP_BIT_SET, OP_SKIP_BIT_CLEAR, OP_SKIP_BIT_SET,
    OP_CALL, OP_ABS_JUMP, OP_REL_BRANCH, OP_BRANCH_W, OP_CALL_W,
    OP_RETURN, OP_RET_INT, OP_RET_LIT, OP_LOAD_LIT, OP_OR_LIT,
    OP_AND_LIT, OP_ADD_LIT, OP_PTR_LOAD, OP_PTR_STORE
  } op_t;

endpackage

//--- verilog/op_decode.sv
`include "core_cfg.svh"

module op_decode
(
  // Instruction word
  input  wire logic [`INSTR_W-1:0]  word, // see [RULE1]
  // Decoded operation
  output core_pkg::op_t             op,
  output core_pkg::class_t          cls,
  // Operand fields
  output logic [`FILE_F_W-1:0]      file_f,
  output logic [2:0]                bit_num,
  output logic                      dst,
  output logic [10:0]               lit,
  output logic                      ptr_num,
  output logic [1:0]                pointer_step_mode
);
  import core_pkg::*;

  logic [5:0] top6;

  always_comb
  begin
    top6              = word[13:8];
    file_f            = word[6:0];                        // see [RULE9]
    bit_num           = word[9:7];                        // see [RULE10]
    dst               = word[7];
    lit               = word[10:0];
    ptr_num           = word[2];                          // see [RULE13]
    pointer_step_mode = word[1:0];                        // see [RULE14]
    cls               = CLS_LITCTRL;
    op                = OP_NOP;
    // Class first from the upper bits, then the operation
    if (word[13:12] == `GRP_BIT)                          // see [RULE18]
    begin
      cls = CLS_BIT;
      case (word[11:10])
        2'h0:    op = OP_BIT_CLR;
        2'h1:    op = OP_BIT_SET;
        2'h2:    op = OP_SKIP_BIT_CLEAR;
        default: op = OP_SKIP_BIT_SET;
      endcase
    end
    else if (word[13:12] == `GRP_K11)
      op = (word[11] == `OPC_CALL) ? OP_CALL : OP_ABS_JUMP;
    else if (top6 == `OPC_ADD_CARRY)                      // see [RULE15]
    begin
      cls = CLS_BYTE;
      op  = OP_ADD_WITH_CARRY;
    end
    else if (word[13:12] == `GRP_BYTE && !(top6 == `OPC_STORE_W && !dst))
    begin
      cls = CLS_BYTE;
      case (top6)
        `OPC_STORE_W:   op = OP_STORE_W;
        // Low two bits of clear-W are don't-care
        `OPC_CLEAR:     op = dst ? OP_CLEAR_F : OP_CLEAR_W; // see [RULE12]
        `OPC_SUB:       op = OP_SUB;
        `OPC_DEC:       op = OP_DEC;
        `OPC_OR:        op = OP_OR;
        `OPC_AND:       op = OP_AND;
        `OPC_ADD:       op = OP_ADD;
        `OPC_MOVE_F:    op = OP_MOVE_F;
        `OPC_COMPL:     op = OP_COMPL;
        `OPC_INC:       op = OP_INC;
        `OPC_DEC_SKIP:  op = OP_DEC_SKIP_ZERO;
        `OPC_ROT_RIGHT: op = OP_ROT_RIGHT;                // see [RULE16]
        `OPC_ROT_LEFT:  op = OP_ROT_LEFT;
        `OPC_INC_SKIP:  op = OP_INC_SKIP_ZERO;
        default:        op = OP_NOP;
      endcase
    end
    else if (word[13:12] == `GRP_BYTE)
    begin
      case (word[6:0])
        `OPC_RETURN:   op = OP_RETURN;
        `OPC_RET_INT:  op = OP_RET_INT;
        `OPC_CALL_W:   op = OP_CALL_W;
        `OPC_BRANCH_W: op = OP_BRANCH_W;
        default:
        begin
          if (word[6:3] == `OPC_PTR_LOAD)
            op = OP_PTR_LOAD;
          else if (word[6:3] == `OPC_PTR_STORE)
            op = OP_PTR_STORE;
          else
            op = OP_NOP;
        end
      endcase
    end
    // Literal group: bits 9:8 of load and return-literal are don't-care
    else if (word[13:10] == `OPC_LOAD_LIT)                // see [RULE12]
      op = OP_LOAD_LIT;
    else if (word[13:10] == `OPC_RET_LIT)
      op = OP_RET_LIT;
    else if (word[13:9] == `OPC_REL_BRANCH)
      op = OP_REL_BRANCH;
    else if (top6 == `OPC_OR_LIT)
      op = OP_OR_LIT;
    else if (top6 == `OPC_AND_LIT)
      op = OP_AND_LIT;
    else if (top6 == `OPC_ADD_LIT)
      op = OP_ADD_LIT;
  end

endmodule

//--- verilog/core_exec.sv
`include "core_cfg.svh"

module core_exec
#(
  parameter int PC_W        = `PC_W_DEFAULT,
  parameter int STACK_DEPTH = `STACK_DEPTH
)
(
  // Clock and reset
  input  wire logic                MCLK,
  input  wire logic                NRST,
  // Program memory
  output logic [PC_W-1:0]          PROG_ADDR,
  input  wire logic [`INSTR_W-1:0] PROG_DATA,
  // File register space
  output logic [`PTR_W-1:0]        FILE_ADDR,
  output logic                     FILE_RD,
  input  wire logic [`DATA_W-1:0]  FILE_RDATA,
  output logic                     FILE_WR,
  output logic [`DATA_W-1:0]       FILE_WDATA,
  // Core state
  output logic [`DATA_W-1:0]       W_REG,
  output logic                     CARRY,
  output logic                     DIGIT_CARRY,
  output logic                     ZERO,
  output logic                     STALL,
  output logic                     INSTR_DONE
);
  import core_pkg::*;

  localparam int SP_W = $clog2(STACK_DEPTH);

  if (PC_W < 11 || PC_W > `PTR_W || STACK_DEPTH < 2 ||
      STACK_DEPTH != (1 << SP_W))
    $error("core_exec: unsupported PC_W or STACK_DEPTH");

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge MCLK or negedge NRST)
  begin
    if (!NRST)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic [`INSTR_W-1:0] ir;
  op_t                 op;
  class_t              cls;
  logic [`FILE_F_W-1:0] file_f;
  logic [2:0]          bit_num;
  logic                dst;
  logic [10:0]         lit;
  logic                ptr_num;
  logic [1:0]          pointer_step_mode;

  op_decode u_dec (
    .word              (ir),
    .op                (op),
    .cls               (cls),
    .file_f            (file_f),
    .bit_num           (bit_num),
    .dst               (dst),
    .lit               (lit),
    .ptr_num           (ptr_num),
    .pointer_step_mode (pointer_step_mode)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  phase_t              phase, next_phase;
  logic [PC_W-1:0]     ir_pc, next_ir_pc, next_prog_addr;
  logic [`INSTR_W-1:0] next_ir;
  logic [1:0]          extra, next_extra;
  logic                ind_extra, next_ind_extra;
  logic [`PTR_W-1:0]   file_select_pointer [2];
  logic [`PTR_W-1:0]   next_fsp [2];
  logic [PC_W-1:0]     stack_mem [STACK_DEPTH];
  logic [SP_W-1:0]     sp, next_sp;
  logic                push;
  logic [PC_W-1:0]     push_val;
  logic [`PTR_W-1:0]   next_file_addr;
  logic                next_file_rd, next_file_wr;
  logic [`DATA_W-1:0]  next_wdata, next_w;
  logic                next_c, next_dc, next_z, next_stall, next_done;

  // Combinational helpers
  logic                file_ref, indirect, flow, skip, wr_f, wr_w;
  logic [`PTR_W-1:0]   ptr_sel, ptr_step, acc_addr;
  logic [`DATA_W-1:0]  rd, res, add_a, add_b;
  logic                cin;
  logic [`DATA_W:0]    sum;
  logic [4:0]          nib;
  logic [PC_W-1:0]     seq_pc, target;

  always_comb
  begin
    next_phase     = phase;
    next_ir        = ir;
    next_ir_pc     = ir_pc;
    next_prog_addr = PROG_ADDR;
    next_extra     = extra;
    next_ind_extra = ind_extra;
    next_fsp       = file_select_pointer;
    next_sp        = sp;
    push           = 1'b0;
    push_val       = '0;
    next_file_addr = FILE_ADDR;
    next_file_rd   = 1'b0;
    next_file_wr   = 1'b0;
    next_wdata     = FILE_WDATA;
    next_w         = W_REG;
    next_c         = CARRY;
    next_dc        = DIGIT_CARRY;
    next_z         = ZERO;
    next_stall     = STALL;
    next_done      = 1'b0;
    rd             = FILE_RDATA;
    seq_pc         = PC_W'(ir_pc + 1'b1);
    // Operand routing
    file_ref = (cls != CLS_LITCTRL && op != OP_CLEAR_W) ||
               op == OP_PTR_LOAD || op == OP_PTR_STORE;
    indirect = op == OP_PTR_LOAD || op == OP_PTR_STORE ||
               file_f <= `INDIRECT_LAST;
    ptr_sel  = (op == OP_PTR_LOAD || op == OP_PTR_STORE) ?
               file_select_pointer[ptr_num] :
               file_select_pointer[file_f[0]];                 // see [RULE13]
    ptr_step = pointer_step_mode[0] ? ptr_sel - 1'b1
                                    : ptr_sel + 1'b1;          // see [RULE14]
    if (op != OP_PTR_LOAD && op != OP_PTR_STORE)
      acc_addr = indirect ? ptr_sel : {9'h000, file_f};
    else
      acc_addr = pointer_step_mode[1] ? ptr_sel : ptr_step;
    // Shared adder: add, add with carry, subtract, add literal
    add_a = (op == OP_ADD_LIT) ? lit[7:0] : rd;
    add_b = (op == OP_SUB) ? ~W_REG : W_REG;
    cin   = (op == OP_SUB) || (op == OP_ADD_WITH_CARRY && CARRY);
    sum   = {1'b0, add_a} + {1'b0, add_b} + {8'h00, cin};
    nib   = {1'b0, add_a[3:0]} + {1'b0, add_b[3:0]} + {4'h0, cin};
    res   = rd;
    wr_f  = 1'b0;
    wr_w  = 1'b0;
    skip  = 1'b0;
    flow  = 1'b0;
    target = seq_pc;

    case (phase)
      PH_Q1:
      begin
        next_phase = PH_Q2;
        if (!STALL)
        begin
          next_file_addr = acc_addr;
          next_file_rd   = file_ref;                          // see [RULE8]
          next_ind_extra = file_ref && indirect &&
                           acc_addr[`PTR_PROG_BIT];           // see [RULE5]
        end
      end
      PH_Q2:
        next_phase = PH_Q3;
      PH_Q3:
      begin
        next_phase = PH_Q4;
        if (!STALL)
        begin
          case (op)                                           // see [RULE7]
            OP_ADD, OP_ADD_WITH_CARRY, OP_SUB, OP_ADD_LIT:     // see [RULE15]
            begin
              res     = sum[7:0];
              next_c  = sum[8];
              next_dc = nib[4];
            end
            OP_AND:            res = rd & W_REG;
            OP_OR:             res = rd | W_REG;
            OP_COMPL:          res = ~rd;
            OP_INC, OP_INC_SKIP_ZERO: res = rd + 1'b1;
            OP_DEC, OP_DEC_SKIP_ZERO: res = rd - 1'b1;
            OP_ROT_RIGHT:                                     // see [RULE16]
            begin
              res    = {CARRY, rd[7:1]};
              next_c = rd[0];
            end
            OP_ROT_LEFT:
            begin
              res    = {rd[6:0], CARRY};
              next_c = rd[7];
            end
            OP_STORE_W, OP_PTR_STORE: res = W_REG;
            OP_CLEAR_F, OP_CLEAR_W:   res = 8'h00;
            OP_BIT_CLR:        res[bit_num] = 1'b0;           // see [RULE10]
            OP_BIT_SET:        res[bit_num] = 1'b1;
            OP_AND_LIT:        res = lit[7:0] & W_REG;
            OP_OR_LIT:         res = lit[7:0] | W_REG;
            OP_LOAD_LIT, OP_RET_LIT: res = lit[7:0];
            default:           res = rd;
          endcase
          // Destination
          if (cls == CLS_BYTE && op != OP_STORE_W && op != OP_CLEAR_F &&
              op != OP_CLEAR_W)
          begin
            wr_f = dst;                                       // see [RULE11]
            wr_w = !dst;
          end
          else
          begin
            wr_f = op == OP_STORE_W || op == OP_CLEAR_F ||
                   op == OP_BIT_CLR || op == OP_BIT_SET ||
                   op == OP_PTR_STORE;
            wr_w = cls == CLS_LITCTRL && op != OP_PTR_STORE &&
                   op != OP_NOP && !(op inside {OP_CALL, OP_ABS_JUMP,
                   OP_REL_BRANCH, OP_BRANCH_W, OP_CALL_W, OP_RETURN,
                   OP_RET_INT});
            wr_w = wr_w || op == OP_CLEAR_W;
          end
          if (wr_w)
            next_w = res;
          if (op != OP_ROT_RIGHT && op != OP_ROT_LEFT &&
              op != OP_RET_LIT && op != OP_NOP &&
              (wr_w || wr_f) && op != OP_STORE_W && op != OP_PTR_STORE &&
              op != OP_BIT_CLR && op != OP_BIT_SET)
            next_z = res == 8'h00;
          next_file_wr = wr_f;
          next_wdata   = res;
          if (op == OP_PTR_LOAD || op == OP_PTR_STORE)
            next_fsp[ptr_num] = ptr_step;
          // Program flow
          case (op)
            OP_SKIP_BIT_CLEAR: skip = !rd[bit_num];
            OP_SKIP_BIT_SET:   skip = rd[bit_num];
            OP_DEC_SKIP_ZERO, OP_INC_SKIP_ZERO: skip = res == 8'h00;
            OP_CALL, OP_ABS_JUMP:
              target = {ir_pc[PC_W-1:11], lit};
            OP_CALL_W:
              target = {ir_pc[PC_W-1:8], W_REG};
            OP_REL_BRANCH:
              target = PC_W'(seq_pc + {{(PC_W-9){lit[8]}}, lit[8:0]});
            OP_BRANCH_W:
              target = PC_W'(seq_pc + {{(PC_W-8){1'b0}}, W_REG});
            OP_RETURN, OP_RET_INT, OP_RET_LIT:
            begin
              target  = stack_mem[SP_W'(sp - 1'b1)];
              next_sp = SP_W'(sp - 1'b1);
            end
            default: target = seq_pc;
          endcase
          if (op == OP_CALL || op == OP_CALL_W)
          begin
            push     = 1'b1;
            push_val = seq_pc;
            next_sp  = SP_W'(sp + 1'b1);
          end
          if (skip)
            target = PC_W'(seq_pc + 1'b1);
          flow = skip || op inside {OP_CALL, OP_CALL_W,            // see [RULE2]
                 OP_RETURN, OP_RET_INT, OP_RET_LIT,              // see [RULE3]
                 OP_ABS_JUMP, OP_REL_BRANCH, OP_BRANCH_W};       // see [RULE4]
          next_extra     = {1'b0, flow} + {1'b0, ind_extra};      // see [RULE5]
          next_prog_addr = target;
        end
      end
      PH_Q4:
      begin
        next_phase = PH_Q1;                                   // see [RULE6]
        if (extra == 2'h0)
        begin
          // Only the last cycle fetches the following word
          next_ir    = PROG_DATA;                             // see [RULE17]
          next_ir_pc = PROG_ADDR;
          next_done  = 1'b1;
          next_stall = 1'b0;
        end
        else
        begin
          next_extra = extra - 1'b1;
          next_stall = 1'b1;
        end
      end
      default: next_phase = PH_Q1;
    endcase
  end

  always_ff @(posedge MCLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase       <= PH_Q1;
      ir          <= `NOP_WORD;
      ir_pc       <= '1;
      PROG_ADDR   <= '0;
      extra       <= 2'h0;
      ind_extra   <= 1'b0;
      file_select_pointer[0] <= '0;
      file_select_pointer[1] <= '0;
      sp          <= '0;
      FILE_ADDR   <= '0;
      FILE_RD     <= 1'b0;
      FILE_WR     <= 1'b0;
      FILE_WDATA  <= 8'h00;
      W_REG       <= 8'h00;
      CARRY       <= 1'b0;
      DIGIT_CARRY <= 1'b0;
      ZERO        <= 1'b0;
      STALL       <= 1'b0;
      INSTR_DONE  <= 1'b0;
    end
    else
    begin
      phase       <= next_phase;
      ir          <= next_ir;
      ir_pc       <= next_ir_pc;
      PROG_ADDR   <= next_prog_addr;
      extra       <= next_extra;
      ind_extra   <= next_ind_extra;
      file_select_pointer <= next_fsp;
      sp          <= next_sp;
      FILE_ADDR   <= next_file_addr;
      FILE_RD     <= next_file_rd;
      FILE_WR     <= next_file_wr;
      FILE_WDATA  <= next_wdata;
      W_REG       <= next_w;
      CARRY       <= next_c;
      DIGIT_CARRY <= next_dc;
      ZERO        <= next_z;
      STALL       <= next_stall;
      INSTR_DONE  <= next_done;
    end
  end

  // Return stack holds no reset state; overflow wraps silently
  always_ff @(posedge MCLK)
  begin
    if (push)
      stack_mem[sp] <= push_val;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Phase still holds Q1 on the release edge; checks start one edge later
  logic checks_on;

  always_ff @(posedge MCLK or negedge rst_n)
  begin
    if (!rst_n)
      checks_on <= 1'b0;
    else
      checks_on <= 1'b1;
  end

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!checks_on);

  property p_phase_walk;
    phase == PH_Q1 |=> phase == PH_Q2 ##1 phase == PH_Q3 ##1 phase == PH_Q4;
  endproperty
  a_phase_walk: assert property (p_phase_walk) // see [RULE6]
    else $error("phase order broken");

  property p_call_two;
    (phase == PH_Q1 && !STALL && (op == OP_CALL || op == OP_CALL_W))
      |-> ##4 (STALL && !INSTR_DONE) ##4 INSTR_DONE;
  endproperty
  a_call_two: assert property (p_call_two) // see [RULE2]
    else $error("call not two cycles");

  property p_ret_two;
    (phase == PH_Q1 && !STALL && op inside {OP_RETURN, OP_RET_INT,
      OP_RET_LIT}) |-> ##4 STALL ##4 (INSTR_DONE && !STALL);
  endproperty
  a_ret_two: assert property (p_ret_two) // see [RULE3]
    else $error("return not two cycles");

  property p_plain_one;
    (phase == PH_Q1 && !STALL && op inside {OP_ADD_WITH_CARRY, OP_AND,
      OP_LOAD_LIT} && !(file_ref && indirect && acc_addr[`PTR_PROG_BIT]))
      |-> ##4 (INSTR_DONE && !STALL);
  endproperty
  a_plain_one: assert property (p_plain_one) // see [RULE15]
    else $error("single-cycle op stretched");

  property p_ind_extra;
    (phase == PH_Q1 && !STALL && file_ref && indirect &&
     acc_addr[`PTR_PROG_BIT]) |-> ##4 STALL;
  endproperty
  a_ind_extra: assert property (p_ind_extra) // see [RULE5]
    else $error("indirect program access not stretched");

  property p_read_first;
    (phase == PH_Q1 && !STALL && file_ref) |=> FILE_RD ##2 !FILE_RD;
  endproperty
  a_read_first: assert property (p_read_first) // see [RULE8]
    else $error("file read missing");

  property p_dest_w;
    (phase == PH_Q3 && !STALL && cls == CLS_BYTE && !dst &&
     op != OP_STORE_W && op != OP_CLEAR_F) |=> !FILE_WR;
  endproperty
  a_dest_w: assert property (p_dest_w) // see [RULE11]
    else $error("d = 0 wrote the file");

  property p_ir_hold;
    STALL |-> $stable(ir) && !INSTR_DONE;
  endproperty
  a_ir_hold: assert property (p_ir_hold) // see [RULE17]
    else $error("fetch during extra cycle");

  property p_rot_flags;
    (phase == PH_Q3 && !STALL && op == OP_ROT_RIGHT)
      |=> $stable(ZERO) && $stable(DIGIT_CARRY) && CARRY == $past(rd[0]);
  endproperty
  a_rot_flags: assert property (p_rot_flags) // see [RULE16]
    else $error("rotate right flags wrong");

endmodule

//--- verif/prog_file_model.sv
`include "core_cfg.svh"

module prog_file_model
(
  // Clock
  input  wire logic                clk,
  // Program memory
  input  wire logic [14:0]         prog_addr,
  output logic [`INSTR_W-1:0]      prog_data,
  // File space
  input  wire logic [`PTR_W-1:0]   file_addr,
  input  wire logic                file_rd,
  output logic [`DATA_W-1:0]       file_rdata,
  input  wire logic                file_wr,
  input  wire logic [`DATA_W-1:0]  file_wdata
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [`INSTR_W-1:0] prog [0:15];
  logic [`DATA_W-1:0]  mem  [0:127];
  logic [`DATA_W-1:0]  rdq;
  logic                rd_d;
  int                  reads;

  initial
  begin
    rd_d  = 1'b0;
    rdq   = 8'h00;
    reads = 0;
  end

  // Asynchronous read, one whole word per fetch
  assign prog_data = prog[prog_addr[3:0]];
  // Data only in the answer cycle; inverted otherwise so no stale match
  assign file_rdata = rd_d ? rdq : ~rdq;

  always @(posedge clk)
  begin
    rd_d <= file_rd;
    if (file_rd)
    begin
      rdq <= mem[file_addr[6:0]];
      if (file_addr == 16'h0020)
        reads <= reads + 1;
    end
    if (file_wr)
      mem[file_addr[6:0]] <= file_wdata;
  end
endmodule

//--- verif/core_exec_tb.sv
module core_exec_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        MCLK;
  logic        NRST;
  logic [14:0] PROG_ADDR;
  logic [13:0] PROG_DATA;
  logic [15:0] FILE_ADDR;
  logic        FILE_RD;
  logic [7:0]  FILE_RDATA;
  logic        FILE_WR;
  logic [7:0]  FILE_WDATA;
  logic [7:0]  W_REG;
  logic        CARRY;
  logic        DIGIT_CARRY;
  logic        ZERO;
  logic        STALL;
  logic        INSTR_DONE;
  int          mismatches;
  int          check_count;

  core_exec core_exec_inst (.MCLK(MCLK), .NRST(NRST),
    .PROG_ADDR(PROG_ADDR), .PROG_DATA(PROG_DATA), .FILE_ADDR(FILE_ADDR),
    .FILE_RD(FILE_RD), .FILE_RDATA(FILE_RDATA), .FILE_WR(FILE_WR),
    .FILE_WDATA(FILE_WDATA), .W_REG(W_REG), .CARRY(CARRY),
    .DIGIT_CARRY(DIGIT_CARRY), .ZERO(ZERO), .STALL(STALL),
    .INSTR_DONE(INSTR_DONE));

  prog_file_model prog_file_model_inst (.clk(MCLK), .prog_addr(PROG_ADDR),
    .prog_data(PROG_DATA), .file_addr(FILE_ADDR), .file_rd(FILE_RD),
    .file_rdata(FILE_RDATA), .file_wr(FILE_WR), .file_wdata(FILE_WDATA));

  initial
  begin
    MCLK = 1'b0;
    forever #2.5 MCLK = ~MCLK;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict;
    if (mismatches == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Cycles to the next decode pulse, and whether a stall showed
  task automatic wait_done(output int n, output logic stalled);
    n = 0;
    stalled = 1'b0;
    do
    begin
      @(negedge MCLK);
      n++;
      if (STALL === 1'b1)
        stalled = 1'b1;
    end while (INSTR_DONE !== 1'b1 && n < 100);
    if (n >= 100)
    begin
      mismatches++;
      give_verdict();
    end
  endtask

  // Load literal, store, jump, add with carry, rotate, call,
  // indirect store into program space, return, jump to self
  task automatic run_timing;
    int   gap;
    logic stalled;
    int   exp_gap [9];
    exp_gap = '{4, 4, 8, 4, 4, 8, 8, 8, 8};
    wait_done(gap, stalled);
    for (int i = 0; i < 9; i++)
    begin
      wait_done(gap, stalled);
      check(16'(gap), 16'(exp_gap[i]));
      check({15'h0, stalled}, {15'h0, exp_gap[i] == 8});
    end
  endtask

  task automatic check_state;
    check({8'h00, W_REG}, 16'h0045);
    check({8'h00, prog_file_model_inst.mem[7'h20]}, 16'h0035);
    check({8'h00, prog_file_model_inst.mem[7'h21]}, 16'h0008);
    check(16'(prog_file_model_inst.reads != 0), 16'h0001);
    check({13'h0, CARRY, DIGIT_CARRY, ZERO}, 16'h0000);
    check({8'h00, prog_file_model_inst.mem[7'h7F]}, 16'h0045);
    check({1'b0, PROG_ADDR}, 16'h0008);
  endtask

  initial
  begin
    NRST = 1'b0;
    mismatches = 0;
    check_count = 0;
    #1;
    for (int i = 0; i < 16; i++)
      prog_file_model_inst.prog[i] = 14'h0000;
    for (int i = 0; i < 128; i++)
      prog_file_model_inst.mem[i] = 8'h00;
    prog_file_model_inst.prog[0] = 14'h3035;
    prog_file_model_inst.prog[1] = 14'h00A0;
    prog_file_model_inst.prog[2] = 14'h2805;
    prog_file_model_inst.prog[5] = 14'h3D21;
    prog_file_model_inst.prog[6] = 14'h0CA1;
    prog_file_model_inst.prog[7] = 14'h200C;
    prog_file_model_inst.prog[8] = 14'h2808;
    // Pre-decrement of pointer 0 from zero lands in program space
    prog_file_model_inst.prog[12] = 14'h0019;
    prog_file_model_inst.prog[13] = 14'h0008;
    prog_file_model_inst.mem[7'h21] = 8'h10;
    repeat (10) @(negedge MCLK);
    NRST = 1'b1;
    run_timing();
    check_state();
    give_verdict();
  end
endmodule
